// >>> pkg/dac_i2c_cfg.svh
`ifndef DAC_I2C_CFG_SVH
`define DAC_I2C_CFG_SVH

// slave address: fixed upper five bits
`define ADDR_FIXED_HI 5'h15
// burst trigger pointer value
`define PTR_BURST 8'hff
// last channel reached in burst
`define LAST_CHANNEL 5'h1f
// highest supported bus rate in kHz
`define BUS_RATE_KHZ 400
// pointer byte field positions
`define PTR_CH_MSB 4
`define PTR_TOP_LSB 5
// first data byte field positions
`define REG_SEL_MSB 7
`define REG_SEL_LSB 6
`define CODE_HI_MSB 5

`endif

// >>> pkg/dac_i2c_pkg.sv
package dac_i2c_pkg;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ADDR = 5'h02,
        ST_PTR  = 5'h04,
        ST_DHI  = 5'h08,
        ST_DLO  = 5'h10
    } port_state_t;

    typedef logic [4:0] channel_index_t;
    typedef logic [13:0] dac_code_word_t;

endpackage : dac_i2c_pkg

// >>> rtl/dac_i2c_slave_write_port.sv
`timescale 1ns/1ns
`include "dac_i2c_cfg.svh"

// What this block does
// R1 - port works only when serial select and protocol select pins are both high
// R2 - pure slave: never drives clock, handles rates up to 400 kHz
// R3 - 7-bit address is 10101 followed by the two address pins
// R4 - start is data falling with clock high; stop is data rising with clock high
// R5 - repeated start keeps the transaction active, not ended
// R6 - master keeps data stable while clock high except start and stop
// R7 - each accepted byte acknowledged by pulling data low in ninth clock
// R8 - idle waits for start plus matching address; direction bit must be zero
// R9 - single update: address, pointer, two data bytes, each acknowledged, then stop
// R10 - without stop, next byte is a new pointer then two data bytes
// R11 - stop at any point ends sequence and returns to idle
// R12 - pointer 0xff starts burst at channel zero
// R13 - burst advances channel after each pair up to 31, then three-byte mode
// R14 - two register-select bits choose destination register of the channel
// R15 - toggle alternation is not applied to burst writes
// R16 - master retries whole transaction when an acknowledge is missing
// R17 - pointer byte: top three bits zero, channel in low five; 0xff reserved
// R18 - first data byte: select bits then code 13..8; second byte code 7..0
module dac_i2c_slave_write_port (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // mode and address pins
    input wire logic i_serial_parallel_select,
    input wire logic i_protocol_select,
    input wire logic i_bus_addr_pin_hi,
    input wire logic i_bus_addr_pin_lo,
    // two-wire link
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    // decoded channel write
    output logic o_wr_valid,
    output dac_i2c_pkg::channel_index_t o_channel_index,
    output logic o_dest_reg_sel_hi,
    output logic o_dest_reg_sel_lo,
    output dac_i2c_pkg::dac_code_word_t o_dac_code_word,
    output logic o_toggle_allowed,
    // status
    output logic o_busy
);
    import dac_i2c_pkg::*;

    //----------------------------------------
    // pin synchronisers and edge detect
    //----------------------------------------
    logic [1:0] scl_sync_q, sda_sync_q, sel_sync_q, prot_sync_q;
    logic [1:0] addr_hi_sync_q, addr_lo_sync_q;
    logic scl_q, sda_q;
    logic scl_rise, scl_fall, start_det, stop_det, enabled;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            sel_sync_q <= 2'h0;
            prot_sync_q <= 2'h0;
            addr_hi_sync_q <= 2'h0;
            addr_lo_sync_q <= 2'h0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], i_scl};
            sda_sync_q <= {sda_sync_q[0], i_sda};
            sel_sync_q <= {sel_sync_q[0], i_serial_parallel_select};
            prot_sync_q <= {prot_sync_q[0], i_protocol_select};
            addr_hi_sync_q <= {addr_hi_sync_q[0], i_bus_addr_pin_hi};
            addr_lo_sync_q <= {addr_lo_sync_q[0], i_bus_addr_pin_lo};
            scl_q <= scl_sync_q[1];
            sda_q <= sda_sync_q[1];
        end
    end

    assign enabled = sel_sync_q[1] & prot_sync_q[1]; // [R1]
    assign scl_rise = enabled & scl_sync_q[1] & ~scl_q;
    assign scl_fall = enabled & ~scl_sync_q[1] & scl_q;
    // data edges while clock held high
    assign start_det = enabled & scl_sync_q[1] & scl_q & sda_q & ~sda_sync_q[1]; // [R4]
    assign stop_det = enabled & scl_sync_q[1] & scl_q & ~sda_q & sda_sync_q[1]; // [R4]

    //----------------------------------------
    // bit counter and shift register
    //----------------------------------------
    port_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic in_frame_q, ack_q, burst_q, addr_match_q;
    logic [7:0] byte_in;
    logic byte_done, addr_match;

    // byte complete on the eighth rising edge
    assign byte_in = {shift_q[6:0], sda_sync_q[1]};
    assign byte_done = scl_rise && bit_cnt_q == 4'h7 && in_frame_q;
    assign addr_match = byte_in == {`ADDR_FIXED_HI, addr_hi_sync_q[1], addr_lo_sync_q[1], 1'b0}; // [R3] [R8]

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
        end else if (start_det || stop_det) begin
            bit_cnt_q <= 4'h0;
        end else if (scl_rise && in_frame_q) begin
            shift_q <= byte_in; // [R6]
            bit_cnt_q <= (bit_cnt_q == 4'h8) ? 4'h0 : bit_cnt_q + 4'h1;
        end
    end

    //----------------------------------------
    // transaction state
    //----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || !enabled) begin
            state_q <= ST_IDLE;
            in_frame_q <= 1'b0;
            burst_q <= 1'b0;
        end else if (stop_det) begin
            state_q <= ST_IDLE; // [R11]
            in_frame_q <= 1'b0;
            burst_q <= 1'b0;
        end else if (start_det) begin
            // repeated start re-arms address phase without freeing the bus
            state_q <= ST_ADDR; // [R5] [R8]
            in_frame_q <= 1'b1;
            burst_q <= 1'b0;
        end else if (byte_done) begin
            unique case (state_q)
                ST_IDLE: state_q <= ST_IDLE;
                ST_ADDR: begin
                    state_q <= addr_match ? ST_PTR : ST_IDLE; // [R8]
                    in_frame_q <= addr_match;
                end
                ST_PTR: begin
                    if (byte_in == `PTR_BURST) begin
                        burst_q <= 1'b1; // [R12]
                        state_q <= ST_DHI;
                    end else if (byte_in[7:`PTR_TOP_LSB] == 3'h0) begin
                        state_q <= ST_DHI; // [R17]
                    end else begin
                        state_q <= ST_IDLE;
                        in_frame_q <= 1'b0;
                    end
                end
                ST_DHI: state_q <= ST_DLO;
                ST_DLO: begin
                    if (burst_q && o_channel_index != `LAST_CHANNEL) begin
                        state_q <= ST_DHI; // [R13]
                    end else begin
                        state_q <= ST_PTR; // [R10] [R13]
                        burst_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    //----------------------------------------
    // acknowledge drive, data line only
    //----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b || !enabled || start_det || stop_det) begin
            ack_q <= 1'b0;
        end else if (scl_fall && bit_cnt_q == 4'h8 && in_frame_q && state_q != ST_IDLE
                     && !(state_q == ST_ADDR && !addr_match_q)
                     && !(state_q == ST_IDLE)) begin
            ack_q <= 1'b1; // [R7]
        end else if (scl_fall) begin
            ack_q <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            addr_match_q <= 1'b0;
        end else if (byte_done) begin
            addr_match_q <= (state_q != ST_ADDR) || addr_match;
        end
    end

    // ack only when the byte was accepted; no clock line output exists
    assign o_sda = 1'b0; // [R2]
    assign o_sda_oe = ack_q; // [R7]
    assign o_busy = in_frame_q;

    //----------------------------------------
    // decoded write capture
    //----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_wr_valid <= 1'b0;
            o_channel_index <= '0;
            o_dest_reg_sel_hi <= 1'b0;
            o_dest_reg_sel_lo <= 1'b0;
            o_dac_code_word <= '0;
            o_toggle_allowed <= 1'b0;
        end else begin
            o_wr_valid <= 1'b0;
            if (byte_done && enabled && !start_det && !stop_det) begin
                unique case (state_q)
                    ST_PTR: begin
                        o_channel_index <= (byte_in == `PTR_BURST) ? 5'h00
                                           : byte_in[`PTR_CH_MSB:0]; // [R12] [R17]
                    end
                    ST_DHI: begin
                        o_dest_reg_sel_hi <= byte_in[`REG_SEL_MSB]; // [R14] [R18]
                        o_dest_reg_sel_lo <= byte_in[`REG_SEL_LSB]; // [R14]
                        o_dac_code_word[13:8] <= byte_in[`CODE_HI_MSB:0]; // [R18]
                    end
                    ST_DLO: begin
                        o_dac_code_word[7:0] <= byte_in; // [R18]
                        o_wr_valid <= 1'b1; // [R9]
                        o_toggle_allowed <= ~burst_q; // [R15]
                    end
                    default: ;
                endcase
            end else if (o_wr_valid && burst_q) begin
                o_channel_index <= o_channel_index + 5'h01; // [R13]
            end
        end
    end

    //----------------------------------------
    // checks
    //----------------------------------------
    a_stop_to_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [R11]
        stop_det |=> state_q == ST_IDLE && !o_busy)
        else $error("stop did not return to idle");
    a_ack_when_match: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [R7]
        o_sda_oe |-> o_busy)
        else $error("ack driven outside a transaction");
    a_disabled_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [R1]
        !enabled |=> !o_sda_oe && state_q == ST_IDLE)
        else $error("port active while deselected");
    a_burst_chan_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [R12]
        (byte_done && state_q == ST_PTR && byte_in == `PTR_BURST && !start_det && !stop_det)
        |=> o_channel_index == 5'h00 && burst_q)
        else $error("burst did not start at channel zero");
    a_burst_no_toggle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [R15]
        o_wr_valid |-> o_toggle_allowed == !$past(burst_q))
        else $error("toggle allowed in burst write");
    a_restart_active: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [R5]
        (start_det && enabled && !stop_det) |=> o_busy && state_q == ST_ADDR)
        else $error("repeated start ended transaction");
    a_ack_edge_low: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [R7]
        $changed(o_sda_oe) |-> !scl_sync_q[1])
        else $error("ack changed while clock high");
    a_write_after_lo: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [R9]
        o_wr_valid |-> $past(state_q) == ST_DLO)
        else $error("write without low data byte");

endmodule : dac_i2c_slave_write_port

// >>> test/i2c_master_model.sv
`timescale 1ns/1ns
module i2c_master_model (
    // clock
    input wire logic i_clk,
    // resolved data wire
    input wire logic i_sda,
    // driven lines
    output logic o_scl,
    output logic o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick
    // also a repeated start when the clock is low
    task automatic start_cond();
        o_sda <= 1'b1;
        tick(4);
        o_scl <= 1'b1;
        tick(4);
        o_sda <= 1'b0;
        tick(4);
        o_scl <= 1'b0;
        tick(4);
    endtask : start_cond
    task automatic stop_cond();
        o_sda <= 1'b0;
        tick(4);
        o_scl <= 1'b1;
        tick(4);
        o_sda <= 1'b1;
        tick(8);
    endtask : stop_cond
    // data moves only while the clock is low
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            o_sda <= b[i];
            tick(4);
            o_scl <= 1'b1;
            tick(8);
            o_scl <= 1'b0;
            tick(4);
        end
        o_sda <= 1'b1;
        tick(4);
        o_scl <= 1'b1;
        tick(4);
        ack = !i_sda; // caller checks the ack against the expected value
        tick(4);
        o_scl <= 1'b0;
        tick(4);
    endtask : send_byte
endmodule : i2c_master_model

// >>> test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import dac_i2c_pkg::*;
    localparam logic [7:0] ADDR = {5'h15, 2'b10, 1'b0};
    logic clk, rst_b, ser_sel, proto_sel, pin_hi, pin_lo, scl, m_sda, sda_w;
    logic sda_out, sda_oe, wr_valid, sel_hi, sel_lo, tog, busy;
    channel_index_t ch;
    dac_code_word_t code;
    int mismatches = 0;
    int checks = 0;
    logic [21:0] wr_q[$];
    assign sda_w = m_sda & ~(sda_oe & ~sda_out);
    dac_i2c_slave_write_port DUT (.i_ref_clk(clk), .i_rst_b(rst_b),
        .i_serial_parallel_select(ser_sel), .i_protocol_select(proto_sel),
        .i_bus_addr_pin_hi(pin_hi), .i_bus_addr_pin_lo(pin_lo), .i_scl(scl),
        .i_sda(sda_w), .o_sda(sda_out), .o_sda_oe(sda_oe), .o_wr_valid(wr_valid),
        .o_channel_index(ch), .o_dest_reg_sel_hi(sel_hi), .o_dest_reg_sel_lo(sel_lo),
        .o_dac_code_word(code), .o_toggle_allowed(tog), .o_busy(busy));
    i2c_master_model bus (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda(m_sda));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (wr_valid === 1'b1) wr_q.push_back({ch, sel_hi, sel_lo, code, tog});
    // ----
    // checking tasks
    // ----
    task automatic chk(input logic [21:0] got, input logic [21:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("mismatches=%0d checks=%0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    task automatic put(input logic [7:0] b, input logic exp_ack);
        logic ack;
        bus.send_byte(b, ack);
        chk(22'(ack), 22'(exp_ack));
    endtask : put
    task automatic chan(input logic [7:0] p, input logic [1:0] s, input logic [13:0] c);
        put(p, 1'b1);
        put({s, c[13:8]}, 1'b1);
        put(c[7:0], 1'b1);
    endtask : chan
    task automatic exp_wr(input logic [4:0] c, input logic [1:0] s, input logic [13:0] d,
                          input logic t);
        chk(22'(wr_q.size()), 22'd1);
        if (wr_q.size() > 0) chk(wr_q.pop_front(), {c, s, d, t});
    endtask : exp_wr
    initial begin
        #400000;
        mismatches++;
        end_of_test();
    end
    // ----
    // scenarios
    // ----
    initial begin
        rst_b = 1'b0;
        ser_sel = 1'b1;
        proto_sel = 1'b1;
        pin_hi = 1'b1;
        pin_lo = 1'b0;
        bus.tick(16);
        rst_b <= 1'b1;
        bus.tick(5);
        bus.start_cond();
        put(ADDR, 1'b1);
        chan(8'h05, 2'b01, 14'h2a5c);
        exp_wr(5'h05, 2'b01, 14'h2a5c, 1'b1);
        bus.stop_cond();
        chk(22'(busy), 22'd0);
        bus.start_cond();
        put(ADDR ^ 8'h02, 1'b0);
        bus.start_cond();
        put(ADDR | 8'h01, 1'b0);
        bus.start_cond();
        put(ADDR, 1'b1);
        chan(8'h1f, 2'b11, 14'h3fff);
        exp_wr(5'h1f, 2'b11, 14'h3fff, 1'b1);
        chan(8'h00, 2'b10, 14'h0001);
        exp_wr(5'h00, 2'b10, 14'h0001, 1'b1);
        put(8'h20, 1'b0);
        bus.stop_cond();
        // burst over every channel, then pointer mode again
        bus.start_cond();
        put(ADDR, 1'b1);
        put(8'hff, 1'b1);
        for (int i = 0; i < 32; i++) begin
            put({i[1:0], 6'(i)}, 1'b1);
            put(8'(i * 3), 1'b1);
            exp_wr(5'(i), 2'(i), {6'(i), 8'(i * 3)}, 1'b0);
        end
        chan(8'h09, 2'b00, 14'h1234);
        exp_wr(5'h09, 2'b00, 14'h1234, 1'b1);
        put(8'hff, 1'b1);
        put(8'h80, 1'b1);
        put(8'h00, 1'b1);
        exp_wr(5'h00, 2'b10, 14'h0000, 1'b0);
        bus.start_cond();
        chk(22'(busy), 22'd1);
        put(ADDR, 1'b1);
        chan(8'h07, 2'b01, 14'h0abc);
        exp_wr(5'h07, 2'b01, 14'h0abc, 1'b1);
        put(8'hff, 1'b1);
        put(8'h01, 1'b1);
        bus.stop_cond();
        chk(22'(busy), 22'd0);
        bus.start_cond();
        put(ADDR, 1'b1);
        chan(8'h03, 2'b11, 14'h0155);
        exp_wr(5'h03, 2'b11, 14'h0155, 1'b1);
        bus.stop_cond();
        proto_sel <= 1'b0;
        bus.tick(5);
        bus.start_cond();
        put(ADDR, 1'b0);
        bus.stop_cond();
        chk(22'(wr_q.size()), 22'd0);
        proto_sel <= 1'b1;
        ser_sel <= 1'b0;
        bus.tick(5);
        bus.start_cond();
        chk(22'(busy), 22'd0);
        put(ADDR, 1'b0);
        bus.stop_cond();
        chk(22'(wr_q.size()), 22'd0);
        end_of_test();
    end
endmodule : tb_top
